// ==== shared/rsds_pkg.sv ====
// Functional notes
// R1: The delay-selection register sits at subaddress 0x20, is eight bits wide and resets to 0x06.
// R2: Bit 0 picks the gap after strobe 1, and each higher bit the next gap, up to bit 7 for strobe 8 to 9.
// R3: A delay bit of 0 waits 2 ms before the next strobe and a bit of 1 waits 5 ms.
// R4: After reset the bits for the gaps after strobes 2 and 3 are 1 and all others are 0.
// R5: Every delay bit reads and writes, and a value kept in nonvolatile storage is reloaded as default.
// R6: A separate bit, held outside the register, picks 2 ms or 5 ms between strobe 9 and strobe 10.
// R7: With the power-down multiplier set, every gap lasts ten times longer during power-down only.
// R8: Each rail has a four-bit strobe code; codes 3h to Ah enable it at that strobe, others leave it alone.
// R9: The host unlocks write protection before writing; writes that are not unlocked are ignored.
package rsds_pkg;

  localparam logic [7:0]  SEQ_DELAY_ADDR  = 8'h20;
  localparam logic [7:0]  SEQ_DELAY_RESET = 8'h06;
  localparam logic [7:0]  READ_ZERO       = 8'h00;

  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned MS_PER_S     = 1000;
  localparam int unsigned SHORT_GAP_MS = 2;
  localparam int unsigned LONG_GAP_MS  = 5;
  localparam int unsigned SHORT_GAP_CYC_DFLT =
    (SHORT_GAP_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;
  localparam int unsigned LONG_GAP_CYC_DFLT =
    (LONG_GAP_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;
  localparam int unsigned DOWN_FACTOR  = 10;
  localparam int unsigned CNT_W        = 24;

  localparam logic [3:0]  STROBE_FIRST = 4'h1;
  localparam logic [3:0]  STROBE_GAP9  = 4'h9;
  localparam logic [3:0]  STROBE_LAST  = 4'ha;
  localparam logic [3:0]  RAIL_CODE_LO = 4'h3;
  localparam logic [3:0]  RAIL_CODE_HI = 4'ha;

  typedef enum logic [1:0] {
    RSDS_OFF,
    RSDS_UP,
    RSDS_ON,
    RSDS_DOWN
  } rsds_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rsds_reg_req_t;

endpackage

// ==== src/rsds_gap_timer.sv ====
`timescale 1ns/1ps
module rsds_gap_timer #(
  parameter int unsigned W = 24
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Control
  input  wire logic         load_i,
  input  wire logic [W-1:0] cycles_i,
  output logic              done_o
);
  logic [W-1:0] count;

  // A load of C makes done_o rise exactly C-1 cycles after the load edge.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else if (load_i) begin
      count <= cycles_i;
    end else if (count != '0) begin
      count <= count - W'(1);
    end
  end

  assign done_o = (count == W'(1));

endmodule // rsds_gap_timer

// ==== src/rsds_top.sv ====
`timescale 1ns/1ps
module rsds_top
  import rsds_pkg::*;
#(
  parameter int unsigned RAILS     = 4,
  parameter int unsigned SHORT_CYC = rsds_pkg::SHORT_GAP_CYC_DFLT,
  parameter int unsigned LONG_CYC  = rsds_pkg::LONG_GAP_CYC_DFLT
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  // Configuration register port
  input  wire rsds_pkg::rsds_reg_req_t reg_req_i,
  input  wire logic                   write_unlocked_i,
  output logic [7:0]                  reg_rdata_o,
  // Nonvolatile storage
  input  wire logic                   nvm_load_i,
  input  wire logic [7:0]             nvm_seq_delay_i,
  output logic [7:0]                  seq_delay_o,
  // Settings held elsewhere in the sequencer
  input  wire logic                   gap_after_strobe_nine_i,
  input  wire logic                   powerdown_delay_multiplier_i,
  input  wire logic [RAILS*4-1:0]     rail_strobe_code_i,
  // Sequence requests and results
  input  wire logic                   power_up_i,
  input  wire logic                   power_down_i,
  output logic [3:0]                  strobe_num_o,
  output logic                        strobe_pulse_o,
  output logic [RAILS-1:0]            rail_en_o,
  output logic                        seq_busy_o
);
  import rsds_pkg::*;

  logic               rst_q1;
  logic               rst_n;
  logic [7:0]         sequence_delay_select;
  rsds_state_t        state;
  rsds_state_t        next_state;
  logic [3:0]         next_strobe;
  logic               next_pulse;
  logic               tmr_load;
  logic [CNT_W-1:0]   tmr_cycles;
  logic               tmr_done;
  logic               up_dir;
  logic               reg_hit;

  // Async assert, synchronous release of the reset.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // R2: gap index to select bit
  function automatic logic gap_long(input logic [7:0] sel, input logic nine,
                                    input logic [3:0] gap);
    if (gap == STROBE_GAP9) begin
      gap_long = nine;
    end else begin
      gap_long = sel[3'(gap - STROBE_FIRST)];
    end
  endfunction

  // R3: 2 ms or 5 ms, R7: ten times on power-down only
  function automatic logic [CNT_W-1:0] gap_cycles(input logic is_long, input logic down,
                                                  input logic mult);
    logic [CNT_W-1:0] base;
    base = is_long ? CNT_W'(LONG_CYC) : CNT_W'(SHORT_CYC);
    if (down && mult) begin
      gap_cycles = CNT_W'(base * DOWN_FACTOR);
    end else begin
      gap_cycles = base;
    end
  endfunction

  // R8: only codes 3h to Ah are driven by the sequencer
  function automatic logic rail_managed(input logic [3:0] code);
    rail_managed = (code >= RAIL_CODE_LO) && (code <= RAIL_CODE_HI);
  endfunction

  assign reg_hit = (reg_req_i.addr == SEQ_DELAY_ADDR);

  // A register write wins over a storage reload arriving in the same cycle.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      // R1: reset value, R4: gaps two and three long
      sequence_delay_select <= SEQ_DELAY_RESET;
    end else if (reg_req_i.wr && reg_hit && write_unlocked_i) begin
      // R9: locked writes dropped, R5: read-write bits
      sequence_delay_select <= reg_req_i.wdata;
    end else if (nvm_load_i) begin
      // R5: stored default reloaded
      sequence_delay_select <= nvm_seq_delay_i;
    end
  end

  assign seq_delay_o = sequence_delay_select;

  // Read data is registered; other subaddresses read as zero here.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= READ_ZERO;
    end else if (reg_req_i.rd) begin
      // R1: register decode
      reg_rdata_o <= reg_hit ? sequence_delay_select : READ_ZERO;
    end
  end

  assign up_dir = (state == RSDS_OFF) || (state == RSDS_UP);

  always_comb begin
    next_state  = state;
    next_strobe = strobe_num_o;
    next_pulse  = 1'b0;
    tmr_load    = 1'b0;
    tmr_cycles  = '0;
    unique case (state)
      RSDS_OFF: begin
        if (power_up_i) begin
          next_state  = RSDS_UP;
          next_strobe = STROBE_FIRST;
          next_pulse  = 1'b1;
          tmr_load    = 1'b1;
          tmr_cycles  = gap_cycles(gap_long(sequence_delay_select, gap_after_strobe_nine_i,
                                            STROBE_FIRST), 1'b0, powerdown_delay_multiplier_i);
        end
      end
      RSDS_UP: begin
        if (tmr_done) begin
          next_strobe = strobe_num_o + 4'h1;
          next_pulse  = 1'b1;
          if (next_strobe == STROBE_LAST) begin
            next_state = RSDS_ON;
          end else begin
            // R3: power-up gap, R6: ninth gap from outside
            tmr_load   = 1'b1;
            tmr_cycles = gap_cycles(gap_long(sequence_delay_select, gap_after_strobe_nine_i,
                                             next_strobe), 1'b0, powerdown_delay_multiplier_i);
          end
        end
      end
      RSDS_ON: begin
        if (power_down_i) begin
          next_state  = RSDS_DOWN;
          next_strobe = STROBE_LAST;
          next_pulse  = 1'b1;
          tmr_load    = 1'b1;
          tmr_cycles  = gap_cycles(gap_long(sequence_delay_select, gap_after_strobe_nine_i,
                                            STROBE_GAP9), 1'b1, powerdown_delay_multiplier_i);
        end
      end
      RSDS_DOWN: begin
        if (tmr_done) begin
          next_strobe = strobe_num_o - 4'h1;
          next_pulse  = 1'b1;
          if (next_strobe == STROBE_FIRST) begin
            next_state = RSDS_OFF;
          end else begin
            // R7: stretched power-down gap
            tmr_load   = 1'b1;
            tmr_cycles = gap_cycles(gap_long(sequence_delay_select, gap_after_strobe_nine_i,
                                             next_strobe - 4'h1), 1'b1,
                                    powerdown_delay_multiplier_i);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state          <= RSDS_OFF;
      strobe_num_o   <= '0;
      strobe_pulse_o <= 1'b0;
    end else begin
      state          <= next_state;
      strobe_num_o   <= next_strobe;
      strobe_pulse_o <= next_pulse;
    end
  end

  assign seq_busy_o = (state == RSDS_UP) || (state == RSDS_DOWN);

  rsds_gap_timer #(
    .W (CNT_W)
  ) u_timer (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n),
    .load_i   (tmr_load),
    .cycles_i (tmr_cycles),
    .done_o   (tmr_done)
  );

  for (genvar r = 0; r < RAILS; r++) begin : g_rail
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        rail_en_o[r] <= 1'b0;
      // R8: rail follows its strobe
      end else if (next_pulse && rail_managed(rail_strobe_code_i[r*4 +: 4])
                   && (rail_strobe_code_i[r*4 +: 4] == next_strobe)) begin
        rail_en_o[r] <= up_dir;
      end
    end
  end

  // Helper logic for the checks below: cycles since the last strobe and the loaded gap.
  logic [CNT_W-1:0] gap_cnt;
  logic [CNT_W-1:0] exp_gap;
  logic             timed_pulse;
  // Counting from one lets gap_cnt equal the loaded gap on the very edge that issues a strobe.
  assign timed_pulse = next_pulse && seq_busy_o;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt <= '0;
      exp_gap <= '0;
    end else begin
      gap_cnt <= next_pulse ? CNT_W'(1) : gap_cnt + CNT_W'(1);
      exp_gap <= tmr_load ? tmr_cycles : exp_gap;
    end
  end

  property p_reset_value;
    @(posedge clk_i) $rose(rst_n) |-> sequence_delay_select == SEQ_DELAY_RESET;
  endproperty
  a_reset_value: assert property (p_reset_value) // R1 R4
    else $error("delay select not at reset value");

  property p_write_taken;
    @(posedge clk_i) disable iff (!rst_n)
      reg_req_i.wr && reg_hit && write_unlocked_i
      ##1 reg_req_i.rd && reg_hit |=> reg_rdata_o == $past(reg_req_i.wdata, 2);
  endproperty
  a_write_taken: assert property (p_write_taken) // R5
    else $error("written value not read back");

  property p_locked_write;
    @(posedge clk_i) disable iff (!rst_n)
      reg_req_i.wr && !write_unlocked_i && !nvm_load_i |=> $stable(sequence_delay_select);
  endproperty
  a_locked_write: assert property (p_locked_write) // R9
    else $error("locked write changed the register");

  property p_unmapped_zero;
    @(posedge clk_i) disable iff (!rst_n)
      reg_req_i.rd && !reg_hit |=> reg_rdata_o == READ_ZERO;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) // R1
    else $error("unmapped read not zero");

  property p_up_gap;
    @(posedge clk_i) disable iff (!rst_n)
      tmr_load && up_dir |-> tmr_cycles == ((next_strobe == STROBE_GAP9) ?
        (gap_after_strobe_nine_i ? CNT_W'(LONG_CYC) : CNT_W'(SHORT_CYC)) :
        (sequence_delay_select[3'(next_strobe - 4'h1)] ? CNT_W'(LONG_CYC) : CNT_W'(SHORT_CYC)));
  endproperty
  a_up_gap: assert property (p_up_gap) // R2 R3 R6
    else $error("power-up gap length wrong");

  property p_down_gap;
    @(posedge clk_i) disable iff (!rst_n)
      tmr_load && !up_dir && powerdown_delay_multiplier_i |->
        (tmr_cycles == CNT_W'(LONG_CYC * DOWN_FACTOR)) ||
        (tmr_cycles == CNT_W'(SHORT_CYC * DOWN_FACTOR));
  endproperty
  a_down_gap: assert property (p_down_gap) // R7
    else $error("power-down gap not multiplied");

  property p_spacing;
    @(posedge clk_i) disable iff (!rst_n)
      timed_pulse |-> gap_cnt == exp_gap;
  endproperty
  a_spacing: assert property (p_spacing) // R3
    else $error("strobe spacing differs from loaded gap");

  property p_rail_rise;
    @(posedge clk_i) disable iff (!rst_n)
      $rose(rail_en_o[0]) |-> strobe_pulse_o && rail_managed(rail_strobe_code_i[3:0])
        && strobe_num_o == rail_strobe_code_i[3:0];
  endproperty
  a_rail_rise: assert property (p_rail_rise) // R8
    else $error("rail enabled off its strobe");

endmodule // rsds_top

// ==== bench/rsds_rail_model.sv ====
`timescale 1ns/1ps
module rsds_rail_model #(
  parameter int unsigned RAILS = 4
) (
  // Clock
  input  wire logic             clk_i,
  // Rail enables from the sequencer
  input  wire logic [RAILS-1:0] rail_en_i,
  // Rail status
  output logic      [RAILS-1:0] rail_good_o
);
  // rail follows enable
  // A rail reports good one cycle after its enable; real outputs ramp far slower.
  always_ff @(posedge clk_i) begin
    rail_good_o <= rail_en_i;
  end
endmodule // rsds_rail_model

// ==== bench/rail_sequencer_delay_select_tb.sv ====
`timescale 1ns/1ps
module rail_sequencer_delay_select_tb;
  import rsds_pkg::*;
  localparam int unsigned SC = 5;
  localparam int unsigned LC = 12;
  logic          clk_i;
  logic          rst_n_i;
  rsds_reg_req_t req;
  logic          unl, nvm_ld, nine, mult, up, down, pulse, busy;
  logic [7:0]    nvm_val, rdata, seq_q, cfg;
  logic [15:0]   codes;
  logic [3:0]    num, rails, good;
  int            num_errors, samples_checked;

  rsds_top #(.RAILS(4), .SHORT_CYC(SC), .LONG_CYC(LC)) uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_req_i(req), .write_unlocked_i(unl),
    .reg_rdata_o(rdata), .nvm_load_i(nvm_ld), .nvm_seq_delay_i(nvm_val),
    .seq_delay_o(seq_q), .gap_after_strobe_nine_i(nine),
    .powerdown_delay_multiplier_i(mult), .rail_strobe_code_i(codes),
    .power_up_i(up), .power_down_i(down), .strobe_num_o(num),
    .strobe_pulse_o(pulse), .rail_en_o(rails), .seq_busy_o(busy));

  rsds_rail_model #(.RAILS(4)) rails_far (.clk_i(clk_i), .rail_en_i(rails), .rail_good_o(good));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic complete_run();
    $display("errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic u);
    @(negedge clk_i);
    unl = u;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_i);
    req = '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_i);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_i);
    req = '0;
    chk({8'h00, rdata}, {8'h00, e}, "read data");
  endtask

  // Rails enabled: on power-up once the strobe has reached their code, on power-down until it does; managed codes only.
  function automatic logic [3:0] mask(input logic [3:0] s, input logic isup);
    logic [3:0] m;
    logic [3:0] c;
    for (int r = 0; r < 4; r++) begin
      c = codes[4*r +: 4];
      m[r] = (c >= 4'h3) && (c <= 4'ha) && (isup ? (c <= s) : (c < s));
    end
    return m;
  endfunction

  function automatic int gap(input int k);
    logic b;
    b = (k <= 8) ? cfg[k-1] : nine;
    return b ? LC : SC;
  endfunction

  task automatic run(input logic isup);
    int         cnt;
    int         expc;
    logic [3:0] s;
    @(negedge clk_i);
    up = isup;
    down = ~isup;
    @(negedge clk_i);
    up = 1'b0;
    down = 1'b0;
    s = isup ? 4'h1 : 4'ha;
    chk({15'h0, pulse}, 16'h1, "first pulse");
    chk({12'h0, num}, {12'h0, s}, "first strobe");
    chk({15'h0, busy}, 16'h1, "busy");
    chk({12'h0, rails}, {12'h0, mask(s, isup)}, "rails");
    for (int k = 1; k < 10; k++) begin
      expc = isup ? gap(s) : gap(s - 4'h1) * (mult ? 10 : 1);
      s = isup ? s + 4'h1 : s - 4'h1;
      cnt = 0;
      do begin
        @(negedge clk_i);
        cnt++;
      end while (pulse !== 1'b1 && cnt < 2000);
      chk(cnt[15:0], expc[15:0], "gap length");
      chk({12'h0, num}, {12'h0, s}, "strobe number");
      chk({12'h0, rails}, {12'h0, mask(s, isup)}, "rails");
    end
    @(negedge clk_i);
    chk({15'h0, busy}, 16'h0, "busy after run");
  endtask

  // Write with a storage reload in the same cycle, then read back on the very next cycle.
  task automatic wr_rd(input logic [7:0] d);
    @(negedge clk_i);
    unl = 1'b1;
    nvm_ld = 1'b1;
    req = '{wr: 1'b1, rd: 1'b0, addr: 8'h20, wdata: d};
    @(negedge clk_i);
    nvm_ld = 1'b0;
    req = '{wr: 1'b0, rd: 1'b1, addr: 8'h20, wdata: 8'h00};
    chk({8'h00, seq_q}, {8'h00, d}, "write over reload");
    @(negedge clk_i);
    req = '0;
    chk({8'h00, rdata}, {8'h00, d}, "back-to-back read");
  endtask

  task automatic test_reset_value();
    chk({8'h00, seq_q}, 16'h0006, "reset value");
    rd(8'h20, 8'h06);
  endtask

  task automatic test_refused_writes();
    wr(8'h20, 8'h33, 1'b0);
    chk({8'h00, seq_q}, 16'h0006, "locked write");
    wr(8'h21, 8'h33, 1'b1);
    chk({8'h00, seq_q}, 16'h0006, "other address write");
    rd(8'h21, 8'h00);
  endtask

  task automatic test_reload_and_write();
    @(negedge clk_i);
    nvm_ld = 1'b1;
    @(negedge clk_i);
    nvm_ld = 1'b0;
    chk({8'h00, seq_q}, 16'h005a, "stored reload");
    wr_rd(8'h3c);
    wr(8'h20, 8'ha5, 1'b1);
    chk({8'h00, seq_q}, 16'h00a5, "unlocked write");
    rd(8'h20, 8'ha5);
  endtask

  // A power-up request while already on must leave strobe and rails alone.
  task automatic test_refused_up();
    @(negedge clk_i);
    up = 1'b1;
    @(negedge clk_i);
    up = 1'b0;
    repeat (2) @(negedge clk_i);
    chk({12'h0, num}, 16'h000a, "request while on");
    chk({12'h0, rails}, {12'h0, mask(4'ha, 1'b1)}, "rails while on");
  endtask

  // Three power-ups and two power-downs of nine gaps each, one power-down stretched ten times, plus register traffic.
  localparam int unsigned WATCHDOG_CYC = 4 * (9 * LC * 14 + 200);

  initial begin
    repeat (WATCHDOG_CYC) @(posedge clk_i);
    num_errors++;
    complete_run();
  end

  initial begin
    num_errors = 0;
    samples_checked = 0;
    rst_n_i = 1'b0;
    req = '0;
    {unl, nvm_ld, nine, mult, up, down} = 6'h00;
    nvm_val = 8'h5a;
    cfg = 8'ha5;
    codes = {4'h7, 4'hb, 4'ha, 4'h3};
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    test_reset_value();
    test_refused_writes();
    test_reload_and_write();
    nine = 1'b1;
    run(1'b1);
    chk({12'h0, good}, {12'h0, mask(4'ha, 1'b1)}, "rails good");
    test_refused_up();
    run(1'b0);
    run(1'b1);
    mult = 1'b1;
    run(1'b0);
    nine = 1'b0;
    run(1'b1);
    complete_run();
  end
endmodule // rail_sequencer_delay_select_tb
